// file: rtl/cst_pkg.sv
// package: constants and types of the clock start-up and trim block
package cst_pkg;
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] TRIM_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] FUSE_OFFSET = 8'h08;
  // ----------------------------------------
  // fuse codes as raw fuse levels
  // ----------------------------------------
  localparam logic [3:0] SEL_EXT_CLOCK = 4'h0;
  localparam logic [3:0] SEL_INT_RC_LO = 4'h1;
  localparam logic [3:0] SEL_INT_RC_HI = 4'h4;
  localparam logic [3:0] SEL_EXT_RC_LO = 4'h5;
  localparam logic [3:0] SEL_EXT_RC_HI = 4'h8;
  localparam logic [3:0] SEL_LF_XTAL = 4'h9;
  localparam logic [1:0] START_CODE_0 = 2'h0;
  localparam logic [1:0] START_CODE_1 = 2'h1;
  localparam logic [1:0] START_CODE_2 = 2'h2;
  localparam logic [1:0] START_CODE_3 = 2'h3;
  // ----------------------------------------
  // counts: start-up in source cycles, delay in watchdog cycles
  // ----------------------------------------
  localparam int COUNT_W = 17;
  localparam logic [16:0] START_6CK = 17'h00006;
  localparam logic [16:0] START_18CK = 17'h00012;
  localparam logic [16:0] START_1KCK = 17'h00400;
  localparam logic [16:0] START_16KCK = 17'h04000;
  localparam logic [16:0] START_32KCK = 17'h08000;
  localparam logic [16:0] DELAY_NONE = 17'h00000;
  localparam logic [16:0] DELAY_4K = 17'h01000;
  localparam logic [16:0] DELAY_64K = 17'h10000;
  localparam logic [16:0] SETTLE_CYCLES = 17'h00005;
  // ----------------------------------------
  // register fields and pin lanes
  // ----------------------------------------
  localparam int STAT_SOURCE_LSB = 0;
  localparam int STAT_BAND_LSB = 3;
  localparam int STAT_STATE_LSB = 5;
  localparam int STAT_RUN_BIT = 8;
  localparam int FUSE_SEL_LSB = 0;
  localparam int FUSE_START_LSB = 4;
  localparam int FUSE_OPT_BIT = 6;
  localparam int PIN_WDT = 0;
  localparam int PIN_SRC = 1;
  localparam int PIN_RC = 2;
  localparam int PIN_SEL = 3;
  localparam int PIN_START = 7;
  localparam int PIN_OPT = 9;
  localparam int PIN_COUNT = 10;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    SRC_EXT_CLOCK = 3'h0,
    SRC_INT_RC = 3'h1,
    SRC_EXT_RC = 3'h2,
    SRC_LF_XTAL = 3'h3,
    SRC_CRYSTAL = 3'h4
  } cst_source_type;
  typedef enum logic [2:0] {
    ST_SAMPLE = 3'h0,
    ST_DELAY = 3'h1,
    ST_START = 3'h3,
    ST_RUN = 3'h2,
    ST_SLEEP = 3'h6,
    ST_WAKE = 3'h7
  } cst_state_type;
  typedef struct packed {
    cst_source_type source;
    logic [1:0] band;
    logic [16:0] start_count;
    logic [16:0] delay_count;
  } cst_cfg_type;
endpackage

// file: rtl/cst_pin_sync.sv
// module: three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ns
module cst_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // pins in
  input wire logic [WIDTH-1:0] pin,
  // filtered out
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
  } cst_sync_type;

  cst_sync_type r;
  cst_sync_type next_r;

  // ----------------------------------------
  // next state; s1 feeds s2 only
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (reset) begin
      next_r = '0;
    end else if (clk_en) begin
      next_r.s1 = pin;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      for (int i = 0; i < WIDTH; i++) begin
        // a change counts only once the last two stages agree
        next_r.rise[i] = r.s2[i] & r.s3[i] & ~r.level[i];
        if (r.s2[i] == r.s3[i]) begin
          next_r.level[i] = r.s3[i];
        end
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign level = r.level;
  assign rise = r.rise;
endmodule

// file: rtl/cst_clock_startup.sv
// module: clock source decode, start-up timing and oscillator trim
//
// What the document requires
// [RL1] fuse 1001 selects low-frequency crystal
// [RL2] crystal start-up 1K or 32K, delay 4K/64K
// [RL3] fuse 0101..1000 selects external RC bands
// [RL4] external RC start-up 18 or 6 cycles
// [RL5] fuse 0001..0100 selects internal RC 1..8 MHz
// [RL6] internal RC start-up 6 cycles plus delay
// [RL7] fuse 0000 selects external clock input
// [RL8] external clock start-up 6 cycles plus delay
// [RL9] reset loads factory byte into trim
// [RL10] watchdog oscillator times the reset delay
// [RL11] trim value raises frequency monotonically
// [RL12] software loads trim for other frequencies
// [RL13] software limits trim during memory writes
// [RL14] internal RC times memory access operations
// [RL15] external clock steps below 2 percent
// [RL16] fuse bit one means unprogrammed
// [RL17] wake-up counts selected source start-up cycles
// [RL18] delay counts 4096 or 65536 watchdog cycles
// [RL19] fuses sampled at reset, held until next
// [RL20] reserved start-up code takes longest timing
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module cst_clock_startup #(
  parameter logic [16:0] DELAY_SHORT_CYCLES = cst_pkg::DELAY_4K,
  parameter logic [16:0] DELAY_LONG_CYCLES = cst_pkg::DELAY_64K,
  parameter logic [16:0] START_SLOW_CYCLES = cst_pkg::START_32KCK,
  parameter logic [16:0] START_XTAL_CYCLES = cst_pkg::START_16KCK
) (
  // clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cst_pkg::ADDR_W-1:0] paddr,
  input wire logic [cst_pkg::DATA_W-1:0] pwdata,
  output logic [cst_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // fuses and factory byte
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic [1:0] startup_time_fuses,
  input wire logic oscillator_option_fuse,
  input wire logic [7:0] factory_trim_byte,
  // oscillator pins
  input wire logic watchdog_osc,
  input wire logic source_osc,
  input wire logic internal_rc_osc,
  // sleep control
  input wire logic sleep_request,
  input wire logic wake_request,
  // outputs
  output logic [2:0] system_clock_source,
  output logic [1:0] frequency_band,
  output logic oscillator_option,
  output logic [7:0] oscillator_trim,
  output logic cpu_run,
  output logic watchdog_tick,
  output logic nvm_timing_tick
);
  typedef struct packed {
    cst_pkg::cst_state_type st;
    cst_pkg::cst_cfg_type cfg;
    logic [3:0] src_sel;
    logic [1:0] start_sel;
    logic opt;
    logic [16:0] remain;
    logic [7:0] trim;
    logic run;
    logic wdt_tick;
    logic nvm_tick;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } cst_core_type;

  cst_core_type r;
  cst_core_type next_r;
  logic [cst_pkg::PIN_COUNT-1:0] pin_level;
  logic [cst_pkg::PIN_COUNT-1:0] pin_rise;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  cst_pin_sync #(.WIDTH(cst_pkg::PIN_COUNT)) u_sync (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .pin({oscillator_option_fuse, startup_time_fuses, clock_source_select_fuses,
          internal_rc_osc, source_osc, watchdog_osc}),
    .level(pin_level),
    .rise(pin_rise)
  );

  // ----------------------------------------
  // fuse decode; bit levels used raw, one is unprogrammed
  // ----------------------------------------
  function automatic cst_pkg::cst_cfg_type decode_fuses(input logic [3:0] src_sel,
                                                        input logic [1:0] start_sel);
    cst_pkg::cst_cfg_type c;
    // crystal modes belong elsewhere; give them the long delay and the 16K-cycle start-up
    c.source = cst_pkg::SRC_CRYSTAL;
    c.band = 2'h0;
    c.start_count = START_XTAL_CYCLES;
    c.delay_count = DELAY_LONG_CYCLES;
    if (src_sel == cst_pkg::SEL_LF_XTAL) begin
      c.source = cst_pkg::SRC_LF_XTAL; // see [RL1]
      unique case (start_sel) // see [RL2]
        cst_pkg::START_CODE_0: begin
          c.start_count = cst_pkg::START_1KCK;
          c.delay_count = DELAY_SHORT_CYCLES;
        end
        cst_pkg::START_CODE_1: begin
          c.start_count = cst_pkg::START_1KCK;
          c.delay_count = DELAY_LONG_CYCLES;
        end
        cst_pkg::START_CODE_2, cst_pkg::START_CODE_3: begin
          c.start_count = START_SLOW_CYCLES; // see [RL20]
          c.delay_count = DELAY_LONG_CYCLES;
        end
      endcase
    end else if (src_sel >= cst_pkg::SEL_EXT_RC_LO && src_sel <= cst_pkg::SEL_EXT_RC_HI) begin
      c.source = cst_pkg::SRC_EXT_RC; // see [RL3]
      c.band = 2'(src_sel - cst_pkg::SEL_EXT_RC_LO);
      c.start_count = cst_pkg::START_18CK; // see [RL4]
      unique case (start_sel)
        cst_pkg::START_CODE_0: c.delay_count = cst_pkg::DELAY_NONE;
        cst_pkg::START_CODE_1: c.delay_count = DELAY_SHORT_CYCLES;
        cst_pkg::START_CODE_2: c.delay_count = DELAY_LONG_CYCLES;
        cst_pkg::START_CODE_3: begin
          c.start_count = cst_pkg::START_6CK;
          c.delay_count = DELAY_SHORT_CYCLES;
        end
      endcase
    end else if (src_sel <= cst_pkg::SEL_INT_RC_HI) begin
      if (src_sel == cst_pkg::SEL_EXT_CLOCK) begin
        c.source = cst_pkg::SRC_EXT_CLOCK; // see [RL7]
      end else begin
        c.source = cst_pkg::SRC_INT_RC; // see [RL5]
        c.band = 2'(src_sel - cst_pkg::SEL_INT_RC_LO);
      end
      c.start_count = cst_pkg::START_6CK; // see [RL6] see [RL8]
      unique case (start_sel)
        cst_pkg::START_CODE_0: c.delay_count = cst_pkg::DELAY_NONE;
        cst_pkg::START_CODE_1: c.delay_count = DELAY_SHORT_CYCLES;
        cst_pkg::START_CODE_2, cst_pkg::START_CODE_3: begin
          c.delay_count = DELAY_LONG_CYCLES; // see [RL20]
        end
      endcase
    end
    return c;
  endfunction

  // register read mux
  function automatic logic [31:0] read_word(input logic [7:0] addr, input cst_core_type s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      cst_pkg::TRIM_OFFSET: w[7:0] = s.trim;
      cst_pkg::STATUS_OFFSET: begin
        w[cst_pkg::STAT_SOURCE_LSB +: 3] = s.cfg.source;
        w[cst_pkg::STAT_BAND_LSB +: 2] = s.cfg.band;
        w[cst_pkg::STAT_STATE_LSB +: 3] = s.st;
        w[cst_pkg::STAT_RUN_BIT] = s.run;
      end
      cst_pkg::FUSE_OFFSET: begin
        w[cst_pkg::FUSE_SEL_LSB +: 4] = s.src_sel;
        w[cst_pkg::FUSE_START_LSB +: 2] = s.start_sel;
        w[cst_pkg::FUSE_OPT_BIT] = s.opt;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    return addr == cst_pkg::TRIM_OFFSET || addr == cst_pkg::STATUS_OFFSET ||
           addr == cst_pkg::FUSE_OFFSET;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (reset) begin
      next_r = '0;
      next_r.st = cst_pkg::ST_SAMPLE;
      next_r.remain = cst_pkg::SETTLE_CYCLES;
      next_r.trim = factory_trim_byte; // see [RL9]
    end else if (clk_en) begin
      // tick outputs, one cycle each
      next_r.wdt_tick = pin_rise[cst_pkg::PIN_WDT]; // see [RL10]
      next_r.nvm_tick = pin_rise[cst_pkg::PIN_RC]; // see [RL14]
      // start-up sequencer
      unique case (r.st)
        cst_pkg::ST_SAMPLE: begin
          // wait for the fuse synchroniser to settle before latching
          if (r.remain == 17'h00000) begin
            next_r.src_sel = pin_level[cst_pkg::PIN_SEL +: 4]; // see [RL19]
            next_r.start_sel = pin_level[cst_pkg::PIN_START +: 2];
            next_r.opt = pin_level[cst_pkg::PIN_OPT];
            next_r.cfg = decode_fuses(pin_level[cst_pkg::PIN_SEL +: 4],
                                      pin_level[cst_pkg::PIN_START +: 2]); // see [RL16]
            if (next_r.cfg.delay_count == cst_pkg::DELAY_NONE) begin
              next_r.st = cst_pkg::ST_START;
              next_r.remain = next_r.cfg.start_count;
            end else begin
              next_r.st = cst_pkg::ST_DELAY;
              next_r.remain = next_r.cfg.delay_count;
            end
          end else begin
            next_r.remain = r.remain - 17'h00001;
          end
        end
        cst_pkg::ST_DELAY: begin
          // counted on watchdog oscillator edges whatever the source
          if (r.remain == 17'h00000) begin
            next_r.st = cst_pkg::ST_START;
            next_r.remain = r.cfg.start_count;
          end else if (pin_rise[cst_pkg::PIN_WDT]) begin
            next_r.remain = r.remain - 17'h00001; // see [RL18]
          end
        end
        cst_pkg::ST_START, cst_pkg::ST_WAKE: begin
          if (r.remain == 17'h00000) begin
            next_r.st = cst_pkg::ST_RUN;
            next_r.run = 1'b1;
          end else if (pin_rise[cst_pkg::PIN_SRC]) begin
            next_r.remain = r.remain - 17'h00001; // see [RL17]
          end
        end
        cst_pkg::ST_RUN: begin
          if (sleep_request) begin
            next_r.st = cst_pkg::ST_SLEEP;
            next_r.run = 1'b0;
          end
        end
        cst_pkg::ST_SLEEP: begin
          if (wake_request) begin
            next_r.st = cst_pkg::ST_WAKE;
            next_r.remain = r.cfg.start_count;
          end
        end
        default: begin
          next_r.st = cst_pkg::ST_SAMPLE;
          next_r.remain = cst_pkg::SETTLE_CYCLES;
        end
      endcase
      // apb: answer prepared in setup, so access has no wait state
      next_r.pready = psel & ~penable;
      if (psel && !penable) begin
        next_r.prdata = read_word(paddr, r);
        next_r.pslverr = ~mapped(paddr);
      end
      if (psel && penable && r.pready && pwrite && paddr == cst_pkg::TRIM_OFFSET) begin
        next_r.trim = pwdata[7:0]; // see [RL11] see [RL12]
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // ----------------------------------------
  // outputs, all from flops
  // ----------------------------------------
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign system_clock_source = r.cfg.source;
  assign frequency_band = r.cfg.band;
  assign oscillator_option = r.opt;
  assign oscillator_trim = r.trim; // trim goes straight to the rc ladder
  assign cpu_run = r.run;
  assign watchdog_tick = r.wdt_tick;
  assign nvm_timing_tick = r.nvm_tick;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  cst_pkg::cst_cfg_type chk_cfg;
  assign chk_cfg = decode_fuses(r.src_sel, r.start_sel);

  sequence latch_s;
    r.st == cst_pkg::ST_SAMPLE && r.remain == 17'h00000 && clk_en;
  endsequence

  trim_reset_load_a: // see [RL9]
    assert property (@(posedge clk) $fell(reset) |-> r.trim == $past(factory_trim_byte))
    else $error("trim not loaded from factory byte");
  lf_xtal_pick_a: // see [RL1]
    assert property (@(posedge clk) disable iff (reset)
      latch_s ##0 (pin_level[6:3] == 4'h9) |=> r.cfg.source == cst_pkg::SRC_LF_XTAL)
    else $error("crystal fuse code not decoded");
  ext_rc_pick_a: // see [RL3]
    assert property (@(posedge clk) disable iff (reset)
      r.src_sel inside {[4'h5:4'h8]} && r.st != cst_pkg::ST_SAMPLE |->
      r.cfg.source == cst_pkg::SRC_EXT_RC && r.cfg.band == 2'(r.src_sel - 4'h5))
    else $error("external rc band wrong");
  int_rc_pick_a: // see [RL5] see [RL6]
    assert property (@(posedge clk) disable iff (reset)
      r.src_sel inside {[4'h1:4'h4]} && r.st != cst_pkg::ST_SAMPLE |->
      r.cfg.source == cst_pkg::SRC_INT_RC && r.cfg.start_count == 17'h00006)
    else $error("internal rc decode wrong");
  ext_clk_pick_a: // see [RL7] see [RL8]
    assert property (@(posedge clk) disable iff (reset)
      r.src_sel == 4'h0 && r.st != cst_pkg::ST_SAMPLE |->
      r.cfg.source == cst_pkg::SRC_EXT_CLOCK && r.cfg.start_count == 17'h00006)
    else $error("external clock decode wrong");
  rc_short_start_a: // see [RL4]
    assert property (@(posedge clk) disable iff (reset)
      r.cfg.source == cst_pkg::SRC_EXT_RC && r.start_sel == 2'h3 |->
      r.cfg.start_count == 17'h00006 && r.cfg.delay_count == DELAY_SHORT_CYCLES)
    else $error("rc fast start-up wrong");
  reserved_longest_a: // see [RL20] see [RL2]
    assert property (@(posedge clk) disable iff (reset)
      r.cfg.source == cst_pkg::SRC_LF_XTAL && r.start_sel == 2'h3 |->
      r.cfg.start_count == START_SLOW_CYCLES && r.cfg.delay_count == DELAY_LONG_CYCLES)
    else $error("reserved code not longest");
  fuses_held_a: // see [RL19]
    assert property (@(posedge clk) disable iff (reset)
      r.st != cst_pkg::ST_SAMPLE |=> $stable(r.cfg) && $stable(r.src_sel) && $stable(r.start_sel))
    else $error("fuse selection changed after sampling");
  delay_wdt_only_a: // see [RL10] see [RL18]
    assert property (@(posedge clk) disable iff (reset)
      r.st == cst_pkg::ST_DELAY && r.remain != 17'h00000 && !(clk_en &&
      pin_rise[cst_pkg::PIN_WDT]) |=> $stable(r.remain))
    else $error("reset delay moved without a watchdog edge");
  run_after_count_a: // see [RL17]
    assert property (@(posedge clk) disable iff (reset)
      $rose(r.run) |-> $past(r.st) inside {cst_pkg::ST_START, cst_pkg::ST_WAKE} &&
      $past(r.remain) == 17'h00000)
    else $error("run before start-up count ended");
  wake_load_a: // see [RL17]
    assert property (@(posedge clk) disable iff (reset)
      r.st == cst_pkg::ST_SLEEP && wake_request && clk_en |=>
      r.st == cst_pkg::ST_WAKE && r.remain == r.cfg.start_count && !r.run)
    else $error("wake did not load start-up count");
  nvm_tick_a: // see [RL14]
    assert property (@(posedge clk) disable iff (reset)
      clk_en && pin_rise[cst_pkg::PIN_RC] |=> nvm_timing_tick ##1 1'b1)
    else $error("memory timing tick missing");
  trim_write_a: // see [RL11]
    assert property (@(posedge clk) disable iff (reset)
      clk_en && psel && penable && pready && pwrite && paddr == 8'h00 |=>
      oscillator_trim == $past(pwdata[7:0]))
    else $error("trim write lost");
  decode_match_a: // see [RL16]
    assert property (@(posedge clk) disable iff (reset)
      r.st != cst_pkg::ST_SAMPLE |-> r.cfg == chk_cfg)
    else $error("held selection differs from fuses");
endmodule

// file: bench/testbench.sv
// testbench: self-checking bench of the clock start-up and trim block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module testbench;
  // ----------------------------------------
  // shortened counts and table rows
  // ----------------------------------------
  localparam int DS = 8;
  localparam int DL = 16;
  localparam int SS = 12;
  localparam int XT = 1024;
  localparam int XC = 10;
  typedef struct packed {
    logic [3:0] sel;
    logic [1:0] stime;
    logic [2:0] src;
    logic [1:0] band;
    int st;
    int dl;
  } cst_row_type;
  cst_row_type rows [15];
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] sel_fuse = 4'h0;
  logic [1:0] start_fuse = 2'h0;
  logic opt_fuse = 1'b0;
  logic [7:0] factory = 8'h00;
  logic sleep_req = 1'b0;
  logic wake_req = 1'b0;
  logic [3:0] osc_cnt = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] src_out;
  logic [1:0] band_out;
  logic opt_out;
  logic [7:0] trim_out;
  logic cpu_run;
  logic wdt_tick;
  logic nvm_tick;
  int mismatches = 0;
  int cmp_count = 0;
  int wdt_seen = 0;
  int nvm_seen = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  // oscillator pins: slow divided levels so the pin filter always settles
  always @(posedge clk) begin
    // steady divided rates: no cycle-to-cycle frequency jump
    osc_cnt <= osc_cnt + 4'h1;
    if (wdt_tick === 1'b1) wdt_seen++;
    if (nvm_tick === 1'b1) nvm_seen++;
  end
  cst_clock_startup #(
    .DELAY_SHORT_CYCLES(17'h00008),
    .DELAY_LONG_CYCLES(17'h00010),
    .START_SLOW_CYCLES(17'h0000c),
    .START_XTAL_CYCLES(17'h0000a)
  ) dut (
    .clk(clk), .reset(reset), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_source_select_fuses(sel_fuse), .startup_time_fuses(start_fuse),
    .oscillator_option_fuse(opt_fuse), .factory_trim_byte(factory),
    .watchdog_osc(osc_cnt[3]), .source_osc(osc_cnt[2]), .internal_rc_osc(osc_cnt[1]),
    .sleep_request(sleep_req), .wake_request(wake_req),
    .system_clock_source(src_out), .frequency_band(band_out), .oscillator_option(opt_out),
    .oscillator_trim(trim_out), .cpu_run(cpu_run), .watchdog_tick(wdt_tick),
    .nvm_timing_tick(nvm_tick)
  );
  // ----------------------------------------
  // bus and sequencing tasks
  // ----------------------------------------
  // apb transfer: request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no fixed wait count: a hung slave is caught by the watchdog
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
  endtask
  // bounded wait for the core to be let run
  task automatic wait_run(input int lim, output int cyc);
    cyc = 0;
    while (cpu_run !== 1'b1 && cyc < lim) begin
      @(posedge clk);
      cyc++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the run needs about 21k cycles
  initial begin
    #3000000;
    mismatches++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    int cyc;
    int e;
    rows = '{'{4'h9, 2'h0, 3'h3, 2'h0, XT, DS}, '{4'h9, 2'h1, 3'h3, 2'h0, XT, DL},
             '{4'h9, 2'h2, 3'h3, 2'h0, SS, DL}, '{4'h9, 2'h3, 3'h3, 2'h0, SS, DL},
             '{4'h0, 2'h0, 3'h0, 2'h0, 6, 0}, '{4'h0, 2'h3, 3'h0, 2'h0, 6, DL},
             '{4'h1, 2'h1, 3'h1, 2'h0, 6, DS}, '{4'h2, 2'h2, 3'h1, 2'h1, 6, DL},
             '{4'h3, 2'h3, 3'h1, 2'h2, 6, DL}, '{4'h4, 2'h0, 3'h1, 2'h3, 6, 0},
             '{4'h5, 2'h0, 3'h2, 2'h0, 18, 0}, '{4'h7, 2'h2, 3'h2, 2'h2, 18, DL},
             '{4'h8, 2'h3, 3'h2, 2'h3, 6, DS}, '{4'ha, 2'h0, 3'h4, 2'h0, XC, DL},
             '{4'h6, 2'h1, 3'h2, 2'h1, 18, DS}};
    for (int i = 0; i < 15; i++) begin
      @(posedge clk);
      sel_fuse <= rows[i].sel;
      start_fuse <= rows[i].stime;
      opt_fuse <= 1'(i);
      factory <= 8'h30 + 8'(i);
      do_reset();
      `CHK("trim in reset", 8'h30 + 8'(i), trim_out)
      `CHK("run in reset", 1'b0, cpu_run)
      // pins: watchdog rises every 16 cycles, source every 8
      e = 6 + rows[i].dl * 16 + rows[i].st * 8;
      wait_run(e + 40, cyc);
      `CHK("start time", 1'b1, cyc inside {[e-24:e+36]})
      `CHK("source", rows[i].src, src_out)
      `CHK("band", rows[i].band, band_out)
      `CHK("option", 1'(i), opt_out)
      apb(1'b0, 8'h04, 32'h0, rd, err);
      `CHK("status", {23'h0, 1'b1, 3'h2, rows[i].band, rows[i].src}, rd)
      apb(1'b0, 8'h08, 32'h0, rd, err);
      `CHK("fuses", {25'h0, 1'(i), rows[i].stime, rows[i].sel}, rd)
      // no memory write runs here, so any trim value is allowed
      apb(1'b1, 8'h00, {24'h0, 8'hc0 ^ 8'(i)}, rd, err);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      `CHK("trim read", {24'h0, 8'hc0 ^ 8'(i)}, rd)
      `CHK("trim pins", 8'hc0 ^ 8'(i), trim_out)
      $display("test %0d done", i);
    end
    // fuses moved after sampling must not alter the running choice
    @(posedge clk);
    sel_fuse <= 4'h1;
    repeat (10) @(posedge clk);
    `CHK("held source", 3'h2, src_out)
    `CHK("held band", 2'h1, band_out)
    $display("test held fuses done");
    // refusals: unmapped, unaligned, read-only write
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    apb(1'b1, 8'h01, 32'h00000055, rd, err);
    `CHK("unaligned err", 1'b1, err)
    apb(1'b1, 8'h08, 32'hffffffff, rd, err);
    apb(1'b0, 8'h08, 32'h0, rd, err);
    `CHK("fuses kept", 32'h00000016, rd)
    // trim end values
    for (int v = 0; v < 2; v++) begin
      apb(1'b1, 8'h00, 32'(v * 255), rd, err);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      `CHK("trim end", 32'(v * 255), rd)
    end
    $display("test registers done");
    // wake outside sleep is ignored, then a full sleep and wake
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("wake in run", 1'b1, cpu_run)
    sleep_req <= 1'b1;
    @(posedge clk);
    sleep_req <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("asleep", 1'b0, cpu_run)
    apb(1'b0, 8'h04, 32'h0, rd, err);
    `CHK("sleep status", {23'h0, 1'b0, 3'h6, 2'h1, 3'h2}, rd)
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    // wake counts only the source start-up, no watchdog delay
    wait_run(300, cyc);
    `CHK("wake time", 1'b1, (cyc >= 18 * 8 - 16) && (cyc <= 18 * 8 + 24))
    `CHK("watchdog ticks", 1'b1, wdt_seen > 0)
    `CHK("memory ticks", 1'b1, nvm_seen > 0)
    $display("test sleep done");
    // clock enable low freezes the sequencer: a sleep request is not taken
    @(posedge clk);
    clk_en <= 1'b0;
    sleep_req <= 1'b1;
    repeat (4) @(posedge clk);
    sleep_req <= 1'b0;
    clk_en <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK("frozen run", 1'b1, cpu_run)
    $display("test clock enable done");
    wrap_up();
  end
endmodule
